// [rtl/auth_command_decoder_zone_access.sv]
// Command decoder and zone access checker behind an AXI4-Lite slave.
// Assumes one 250 MHz clock; the command engines sit outside and
// start on opStart; framing and CRC are checked before this block.
// Summary of operation
// - Busy and deaf to pins through execution
// - 0x1C starts key derivation, 14 ms
// - 0x30 returns revision info, 0.4 ms
// - 0x15 generates data-protection digest, 11 ms
// - 0x11 computes HMAC response, 27 ms
// - 0x28 verifies a peer MAC, 12 ms
// - 0x17 permanently locks a zone, 5 ms
// - 0x08 computes SHA-256 response, 12 ms
// - 0x16 makes random value and nonce, 22 ms
// - 0x01 idles only this device, 0.4 ms
// - 0x1B returns a random number, 11 ms
// - 0x02 reads four bytes, 0.4 ms
// - 0x20 updates config byte 84/85, 8 ms
// - 0x12 writes 4 or 32 bytes, 4 ms
// - First parameter byte selects zone 0/1/2
// - OTP read after lock, not legacy
// - Data read after lock, per slot flags
// - OTP/data writes need config lock set
// - After value lock, OTP mode governs writes
// - After value lock, slot policy governs writes
// - Illegal command skips execution, status 0x03
`timescale 1ns/100ps
`include "auth_cmd_params.svh"

module auth_command_decoder_zone_access
  import auth_cmd_pkg::*;
#(
  parameter int KEYDER_CYC = `MS_TO_CYC(`TYP_KEYDER_MS),
  parameter int REVISION_CYC = `MS_TO_CYC(`TYP_REVISION_MS),
  parameter int DIGEST_CYC = `MS_TO_CYC(`TYP_DIGEST_MS),
  parameter int HMAC_CYC = `MS_TO_CYC(`TYP_HMAC_MS),
  parameter int CHECKMAC_CYC = `MS_TO_CYC(`TYP_CHECKMAC_MS),
  parameter int LOCK_CYC = `MS_TO_CYC(`TYP_LOCK_MS),
  parameter int MAC_CYC = `MS_TO_CYC(`TYP_MAC_MS),
  parameter int NONCE_CYC = `MS_TO_CYC(`TYP_NONCE_MS),
  parameter int PAUSE_CYC = `MS_TO_CYC(`TYP_PAUSE_MS),
  parameter int RANDOM_CYC = `MS_TO_CYC(`TYP_RANDOM_MS),
  parameter int READ_CYC = `MS_TO_CYC(`TYP_READ_MS),
  parameter int CFGUPD_CYC = `MS_TO_CYC(`TYP_CFGUPD_MS),
  parameter int WRITE_CYC = `MS_TO_CYC(`TYP_WRITE_MS)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy,
  output logic pinsIgnored,
  output logic opStart,
  output logic [7:0] opCode,
  output logic [7:0] statusCode
);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int MIN_CYC = 1;
  if (KEYDER_CYC < MIN_CYC || REVISION_CYC < MIN_CYC || DIGEST_CYC < MIN_CYC
      || HMAC_CYC < MIN_CYC || CHECKMAC_CYC < MIN_CYC || LOCK_CYC < MIN_CYC
      || MAC_CYC < MIN_CYC || NONCE_CYC < MIN_CYC || PAUSE_CYC < MIN_CYC
      || RANDOM_CYC < MIN_CYC || READ_CYC < MIN_CYC || CFGUPD_CYC < MIN_CYC
      || WRITE_CYC < MIN_CYC) begin : badCycles
    $error("Execution cycle counts must be at least one");
  end

  state_t state;
  logic [31:0] cmdReg;
  logic [15:0] param2Reg;
  logic [31:0] locksReg;
  logic [15:0] slotSecret;
  logic [15:0] slotEncRead;
  logic [63:0] slotWrPolicy;
  logic done;
  logic [31:0] execCount;

  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrFire;
  logic rdFire;
  logic startReq;

  // AXI write channel: address and data taken in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  function automatic logic wrMapped(input logic [7:0] a);
    wrMapped = (a == `REG_CMD) || (a == `REG_PARAM2) || (a == `REG_CTRL)
      || (a == `REG_LOCKS) || (a == `REG_SECRET) || (a == `REG_ENCREAD)
      || (a == `REG_WRPOL_LO) || (a == `REG_WRPOL_HI)
      || (a == `REG_STATUS);
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // Command registers frozen while busy so a half-written command
  // cannot disturb the one executing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmdReg <= `CMD_RESET;
      param2Reg <= 16'h0000;
    end else if (wrFire && !busy) begin
      if (awAddr == `REG_CMD) begin
        cmdReg <= merge(cmdReg, wData, wStrb);
      end else if (awAddr == `REG_PARAM2) begin
        param2Reg <= 16'(merge({16'h0000, param2Reg}, wData, wStrb));
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      locksReg <= `LOCKS_RESET;
      slotSecret <= `SLOT_RESET;
      slotEncRead <= `SLOT_RESET;
      slotWrPolicy <= `WRPOL_RESET;
    end else if (wrFire && !busy) begin
      if (awAddr == `REG_LOCKS) begin
        locksReg <= merge(locksReg, wData, wStrb) & 32'h0000_000F;
      end else if (awAddr == `REG_SECRET) begin
        slotSecret <= 16'(merge({16'h0000, slotSecret}, wData, wStrb));
      end else if (awAddr == `REG_ENCREAD) begin
        slotEncRead <= 16'(merge({16'h0000, slotEncRead}, wData, wStrb));
      end else if (awAddr == `REG_WRPOL_LO) begin
        slotWrPolicy[31:0] <= merge(slotWrPolicy[31:0], wData, wStrb);
      end else if (awAddr == `REG_WRPOL_HI) begin
        slotWrPolicy[63:32] <= merge(slotWrPolicy[63:32], wData, wStrb);
      end
    end
  end

  // A start written while busy is dropped
  assign startReq = wrFire && !busy && (awAddr == `REG_CTRL)
    && wStrb[0] && wData[`CTRL_START_BIT];

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == `REG_CMD) begin
        s_axi_rdata <= cmdReg;
      end else if (s_axi_araddr == `REG_PARAM2) begin
        s_axi_rdata <= {16'h0000, param2Reg};
      end else if (s_axi_araddr == `REG_CTRL) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == `REG_STATUS) begin
        s_axi_rdata <= {16'h0000, statusCode, 6'h00, done, busy};
      end else if (s_axi_araddr == `REG_LOCKS) begin
        s_axi_rdata <= locksReg;
      end else if (s_axi_araddr == `REG_SECRET) begin
        s_axi_rdata <= {16'h0000, slotSecret};
      end else if (s_axi_araddr == `REG_ENCREAD) begin
        s_axi_rdata <= {16'h0000, slotEncRead};
      end else if (s_axi_araddr == `REG_WRPOL_LO) begin
        s_axi_rdata <= slotWrPolicy[31:0];
      end else if (s_axi_araddr == `REG_WRPOL_HI) begin
        s_axi_rdata <= slotWrPolicy[63:32];
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Command fields
  logic [7:0] cmdOpcode;
  logic [7:0] firstParameterByte;
  logic [7:0] cmdCount;
  logic configurationLockFlag;
  logic valueLockFlag;
  otp_mode_t oneTimeProgModeSetting;
  zone_t zone;
  logic encReq;
  logic [3:0] dataSlot;
  logic [4:0] cfgWord;
  logic [3:0] slotWritePolicyField;

  assign cmdOpcode = cmdReg[`CMD_OPCODE_LSB +: 8];
  assign firstParameterByte = cmdReg[`CMD_FIRST_PARAMETER_BYTE_LSB +: 8];
  assign cmdCount = cmdReg[`CMD_COUNT_LSB +: 8];
  assign configurationLockFlag = locksReg[`LOCKS_CFG_BIT];
  assign valueLockFlag = locksReg[`LOCKS_VALUE_BIT];
  assign oneTimeProgModeSetting = otp_mode_t'(locksReg[`LOCKS_OTP_LSB +: 2]);
  assign zone = zone_t'(firstParameterByte[1:0]);
  assign encReq = firstParameterByte[`P1_ENCRYPT_BIT];
  assign dataSlot = param2Reg[6:3];
  assign cfgWord = param2Reg[4:0];
  assign slotWritePolicyField = slotWrPolicy[dataSlot*4 +: 4];

  // Opcode decode with execution time per command
  logic opKnown;
  int execCycles;

  always_comb begin
    opKnown = 1'b1;
    execCycles = MIN_CYC;
    case (cmdOpcode)
      `OPC_KEYDER: execCycles = KEYDER_CYC;
      `OPC_REVISION: execCycles = REVISION_CYC;
      `OPC_DIGEST: execCycles = DIGEST_CYC;
      `OPC_HMAC: execCycles = HMAC_CYC;
      `OPC_CHECKMAC: execCycles = CHECKMAC_CYC;
      `OPC_LOCK: execCycles = LOCK_CYC;
      `OPC_MAC: execCycles = MAC_CYC;
      `OPC_NONCE: execCycles = NONCE_CYC;
      `OPC_PAUSE: execCycles = PAUSE_CYC;
      `OPC_RANDOM: execCycles = RANDOM_CYC;
      `OPC_READ: execCycles = READ_CYC;
      `OPC_CFGUPD: execCycles = CFGUPD_CYC;
      `OPC_WRITE: execCycles = WRITE_CYC;
      default: opKnown = 1'b0;
    endcase
  end

  // Zone access decision for read and write
  logic isRead;
  logic isWrite;
  logic readAllowed;
  logic writeAllowed;
  logic parseBad;
  logic accessBad;

  assign isRead = (cmdOpcode == `OPC_READ);
  assign isWrite = (cmdOpcode == `OPC_WRITE);

  always_comb begin
    readAllowed = 1'b0;
    case (zone)
      ZONE_CONFIG: readAllowed = 1'b1;
      ZONE_OTP: readAllowed = valueLockFlag
        && (oneTimeProgModeSetting != OTP_LEGACY);
      ZONE_DATA: readAllowed = valueLockFlag && (!slotSecret[dataSlot]
        || (slotEncRead[dataSlot] && encReq));
      default: readAllowed = 1'b0;
    endcase
  end

  always_comb begin
    writeAllowed = 1'b0;
    case (zone)
      ZONE_CONFIG: writeAllowed = !configurationLockFlag && !encReq
        && (cfgWord >= `CFG_WR_FIRST) && (cfgWord <= `CFG_WR_LAST);
      ZONE_OTP: begin
        if (!configurationLockFlag) begin
          writeAllowed = 1'b0;
        end else if (!valueLockFlag) begin
          writeAllowed = 1'b1;
        end else begin
          writeAllowed = (oneTimeProgModeSetting == OTP_CONSUMPTION);
        end
      end
      ZONE_DATA: begin
        if (!configurationLockFlag) begin
          writeAllowed = 1'b0;
        end else if (!valueLockFlag) begin
          writeAllowed = 1'b1;
        end else begin
          writeAllowed = (slotWritePolicyField == `WRPOL_OPEN)
            || ((slotWritePolicyField == `WRPOL_ENCRYPTED) && encReq);
        end
      end
      default: writeAllowed = 1'b0;
    endcase
  end

  // Reserved zone on a read or write, unknown opcode or short packet is a parse error
  assign parseBad = !opKnown || (cmdCount < `MIN_COUNT)
    || ((isRead || isWrite) && (zone == ZONE_RESERVED));
  assign accessBad = (isRead && !readAllowed) || (isWrite && !writeAllowed);

  // Command sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      execCount <= 32'h0000_0000;
      statusCode <= `ST_SUCCESS;
      opStart <= 1'b0;
      opCode <= 8'h00;
    end else begin
      opStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (startReq) begin
            state <= ST_PARSE;
          end
        end
        ST_PARSE: begin
          if (parseBad) begin
            statusCode <= `ST_PARSE_ERR;
            state <= ST_IDLE;
          end else if (accessBad) begin
            statusCode <= `ST_EXEC_ERR;
            state <= ST_IDLE;
          end else begin
            execCount <= 32'(execCycles - 1);
            opStart <= 1'b1;
            opCode <= cmdOpcode;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (execCount == 32'h0000_0000) begin
            statusCode <= `ST_SUCCESS;
            state <= ST_IDLE;
          end else begin
            execCount <= execCount - 32'h0000_0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Done flag: start clears it, finishing sets it; set wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else if (state != ST_IDLE && (state == ST_PARSE ? (parseBad || accessBad)
                 : execCount == 32'h0000_0000)) begin
      done <= 1'b1;
    end else if (startReq) begin
      done <= 1'b0;
    end
  end

  assign busy = (state != ST_IDLE);
  assign pinsIgnored = busy;

endmodule

// [rtl/auth_cmd_params.svh]
// Constants for the command decoder and zone access checker.
// Assumes a 250 MHz core clock and 32-bit AXI4-Lite register access.
`ifndef AUTH_CMD_PARAMS_SVH
`define AUTH_CMD_PARAMS_SVH

`define CORE_CLK_MHZ 250

// Register byte offsets
`define REG_CMD 8'h00
`define REG_PARAM2 8'h04
`define REG_CTRL 8'h08
`define REG_STATUS 8'h0C
`define REG_LOCKS 8'h10
`define REG_SECRET 8'h14
`define REG_ENCREAD 8'h18
`define REG_WRPOL_LO 8'h1C
`define REG_WRPOL_HI 8'h20

// Field positions
`define CMD_OPCODE_LSB 0
`define CMD_FIRST_PARAMETER_BYTE_LSB 8
`define CMD_COUNT_LSB 16
`define CTRL_START_BIT 0
`define LOCKS_CFG_BIT 0
`define LOCKS_VALUE_BIT 1
`define LOCKS_OTP_LSB 2
`define P1_ENCRYPT_BIT 6
`define P1_WIDE_BIT 7

// Reset values
`define CMD_RESET 32'h0000_0000
`define LOCKS_RESET 32'h0000_0000
`define SLOT_RESET 16'h0000
`define WRPOL_RESET 64'h0000_0000_0000_0000

// Opcodes
`define OPC_KEYDER 8'h1C
`define OPC_REVISION 8'h30
`define OPC_DIGEST 8'h15
`define OPC_HMAC 8'h11
`define OPC_CHECKMAC 8'h28
`define OPC_LOCK 8'h17
`define OPC_MAC 8'h08
`define OPC_NONCE 8'h16
`define OPC_PAUSE 8'h01
`define OPC_RANDOM 8'h1B
`define OPC_READ 8'h02
`define OPC_CFGUPD 8'h20
`define OPC_WRITE 8'h12

// Status codes
`define ST_SUCCESS 8'h00
`define ST_PARSE_ERR 8'h03
`define ST_EXEC_ERR 8'h0F

// Packet limits and config write window
`define MIN_COUNT 8'h07
`define CFG_WR_FIRST 5'h04
`define CFG_WR_LAST 5'h0F
`define WRPOL_OPEN 4'h0
`define WRPOL_ENCRYPTED 4'h4

// Typical execution times, ms
`define TYP_KEYDER_MS 14.0
`define TYP_REVISION_MS 0.4
`define TYP_DIGEST_MS 11.0
`define TYP_HMAC_MS 27.0
`define TYP_CHECKMAC_MS 12.0
`define TYP_LOCK_MS 5.0
`define TYP_MAC_MS 12.0
`define TYP_NONCE_MS 22.0
`define TYP_PAUSE_MS 0.4
`define TYP_RANDOM_MS 11.0
`define TYP_READ_MS 0.4
`define TYP_CFGUPD_MS 8.0
`define TYP_WRITE_MS 4.0
`define MS_TO_CYC(t) (int'((t) * 1000.0 * `CORE_CLK_MHZ))

`endif

// [rtl/auth_cmd_pkg.sv]
// Types shared by the command decoder.
// Assumes the constants header is included alongside.
package auth_cmd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PARSE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    ZONE_CONFIG = 2'b00,
    ZONE_OTP = 2'b01,
    ZONE_DATA = 2'b10,
    ZONE_RESERVED = 2'b11
  } zone_t;

  typedef enum logic [1:0] {
    OTP_LEGACY = 2'b00,
    OTP_READ_ONLY = 2'b01,
    OTP_CONSUMPTION = 2'b10,
    OTP_SPARE = 2'b11
  } otp_mode_t;
endpackage

// [sim/auth_cmd_asserts.sv]
// Checker for the command decoder: busy window, run length and status.
// Assumes a bind onto the decoder top that passes its cycle parameters on.
`timescale 1ns/100ps
`include "auth_cmd_params.svh"

module auth_cmd_asserts #(
  parameter int KEYDER_CYC = 1, parameter int REVISION_CYC = 1, parameter int DIGEST_CYC = 1,
  parameter int HMAC_CYC = 1, parameter int CHECKMAC_CYC = 1, parameter int LOCK_CYC = 1,
  parameter int MAC_CYC = 1, parameter int NONCE_CYC = 1, parameter int PAUSE_CYC = 1,
  parameter int RANDOM_CYC = 1, parameter int READ_CYC = 1, parameter int CFGUPD_CYC = 1,
  parameter int WRITE_CYC = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic pinsIgnored,
  input wire logic opStart,
  input wire logic [7:0] opCode,
  input wire logic [7:0] statusCode
);
  logic [31:0] busyLen;
  logic ran;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) busyLen <= 32'h0000_0000;
    else if (busy) busyLen <= busyLen + 32'h0000_0001;
    else busyLen <= 32'h0000_0000;
  end

  // Marks a busy window that reached execution
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ran <= 1'b0;
    else if (opStart) ran <= 1'b1;
    else if (!busy) ran <= 1'b0;
  end

  function automatic int expLen(logic [7:0] op);
    case (op)
      `OPC_KEYDER: return 1 + KEYDER_CYC;
      `OPC_REVISION: return 1 + REVISION_CYC;
      `OPC_DIGEST: return 1 + DIGEST_CYC;
      `OPC_HMAC: return 1 + HMAC_CYC;
      `OPC_CHECKMAC: return 1 + CHECKMAC_CYC;
      `OPC_LOCK: return 1 + LOCK_CYC;
      `OPC_MAC: return 1 + MAC_CYC;
      `OPC_NONCE: return 1 + NONCE_CYC;
      `OPC_PAUSE: return 1 + PAUSE_CYC;
      `OPC_RANDOM: return 1 + RANDOM_CYC;
      `OPC_READ: return 1 + READ_CYC;
      `OPC_CFGUPD: return 1 + CFGUPD_CYC;
      `OPC_WRITE: return 1 + WRITE_CYC;
      default: return 1;
    endcase
  endfunction

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence parse_only;
    $rose(busy) ##1 !busy;
  endsequence
  sequence exec_entry;
    $rose(busy) ##1 opStart;
  endsequence

  busy_deaf_a: assert property (busy == pinsIgnored)
    else $error("pin ignore differs from busy");
  start_busy_a: assert property (opStart |-> busy)
    else $error("start outside busy");
  parse_step_a: assert property ($rose(busy) |=> (opStart || !busy))
    else $error("parse step longer than one cycle");
  start_once_a: assert property (exec_entry |=> !opStart)
    else $error("start pulse too long");
  opcode_hold_a: assert property (busy && !opStart |-> $stable(opCode))
    else $error("opcode changed while busy");
  run_length_a: assert property ($fell(busy) |->
    int'(busyLen) == (ran ? expLen(opCode) : 1))
    else $error("busy length wrong");
  known_op_a: assert property (opStart |-> opCode inside {`OPC_KEYDER, `OPC_REVISION,
    `OPC_DIGEST, `OPC_HMAC, `OPC_CHECKMAC, `OPC_LOCK, `OPC_MAC, `OPC_NONCE, `OPC_PAUSE,
    `OPC_RANDOM, `OPC_READ, `OPC_CFGUPD, `OPC_WRITE})
    else $error("unknown opcode executed");
  refusal_code_a: assert property (parse_only |->
    (statusCode == `ST_PARSE_ERR || statusCode == `ST_EXEC_ERR))
    else $error("refused command without error code");
  success_code_a: assert property ($fell(busy) && ran |-> statusCode == `ST_SUCCESS)
    else $error("executed command without success code");
endmodule

// [sim/host_model.sv]
// Host controller model: AXI4-Lite master that issues commands and polls.
// Assumes the decoder slave ports and one shared clock.
`timescale 1ns/100ps
`include "auth_cmd_params.svh"

module host_model (
  input wire logic core_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Waits the typical time first; the bench timeout bounds the polling
  task automatic poll(input int typ, output logic [31:0] st);
    logic [1:0] r;
    repeat (typ) @(posedge core_clk);
    st = 32'h0000_0001;
    while (st[0] || !st[1]) rd(`REG_STATUS, st, r);
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the command decoder and zone access checker.
// Assumes the host model for register traffic and the checker bound below.
`timescale 1ns/100ps
`include "auth_cmd_params.svh"

module testbench;
  localparam logic [7:0] OPS [13] = '{`OPC_KEYDER, `OPC_REVISION, `OPC_DIGEST, `OPC_HMAC,
    `OPC_CHECKMAC, `OPC_LOCK, `OPC_MAC, `OPC_NONCE, `OPC_PAUSE, `OPC_RANDOM, `OPC_READ,
    `OPC_CFGUPD, `OPC_WRITE};
  localparam int CYC [13] = '{14, 4, 11, 27, 12, 5, 12, 22, 4, 11, 4, 8, 4};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr, opCode, statusCode;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy, pinsIgnored, opStart;
  int nErrors = 0;
  int comparisons = 0;
  int cycles = 0;
  int busyRun = 0;
  int lastRun = 0;

  always #2 core_clk = ~core_clk;

  auth_command_decoder_zone_access #(.KEYDER_CYC(CYC[0]), .REVISION_CYC(CYC[1]),
    .DIGEST_CYC(CYC[2]), .HMAC_CYC(CYC[3]), .CHECKMAC_CYC(CYC[4]), .LOCK_CYC(CYC[5]),
    .MAC_CYC(CYC[6]), .NONCE_CYC(CYC[7]), .PAUSE_CYC(CYC[8]), .RANDOM_CYC(CYC[9]),
    .READ_CYC(CYC[10]), .CFGUPD_CYC(CYC[11]), .WRITE_CYC(CYC[12])
  ) u_auth_command_decoder_zone_access (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy, .pinsIgnored, .opStart,
    .opCode, .statusCode);

  host_model u_host_model (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  task automatic test_done;
    if (nErrors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Word is {count, first parameter byte, opcode}
  task automatic cmd(input logic [23:0] c, input logic [15:0] p2, input int typ,
                     input logic [7:0] exp);
    u_host_model.wr(`REG_CMD, {8'h00, c});
    u_host_model.wr(`REG_PARAM2, {16'h0000, p2});
    u_host_model.wr(`REG_CTRL, 32'h0000_0001);
    u_host_model.poll(typ, st);
    check({24'h00_0000, st[15:8]}, {24'h00_0000, exp});
  endtask

  // Length of the last busy window, counted independently of the checker
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busyRun <= busyRun + 1;
    else if (busyRun != 0) begin
      lastRun <= busyRun;
      busyRun <= 0;
    end
    if (cycles == 20000) begin
      nErrors++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    u_host_model.rd(`REG_STATUS, st, resp);
    check(st, 32'h0000_0000);
    u_host_model.rd(8'h24, st, resp);
    check({30'h0000_0000, resp}, 32'h0000_0002);
    u_host_model.wr(8'h24, 32'h0000_0000);
    check({30'h0000_0000, s_axi_bresp}, 32'h0000_0002);
    for (int i = 0; i < 13; i++) begin
      cmd({16'h0700, OPS[i]}, 16'h0004, CYC[i], `ST_SUCCESS);
      check(32'(lastRun), 32'(1 + CYC[i]));
      check({24'h00_0000, opCode}, {24'h00_0000, OPS[i]});
    end
    cmd({16'h0700, 8'h05}, 16'h0004, 0, `ST_PARSE_ERR);
    cmd({16'h0600, `OPC_READ}, 16'h0004, 0, `ST_PARSE_ERR);
    cmd({16'h0703, `OPC_READ}, 16'h0004, 0, `ST_PARSE_ERR);
    check(32'(lastRun), 32'h0000_0001);
    cmd({16'h0701, `OPC_READ}, 16'h0000, 0, `ST_EXEC_ERR);
    cmd({16'h0702, `OPC_READ}, 16'h0000, 0, `ST_EXEC_ERR);
    cmd({16'h0701, `OPC_WRITE}, 16'h0000, 0, `ST_EXEC_ERR);
    cmd({16'h0700, `OPC_WRITE}, 16'h0002, 0, `ST_EXEC_ERR);
    cmd({16'h0740, `OPC_WRITE}, 16'h0004, 0, `ST_EXEC_ERR);
    u_host_model.wr(`REG_LOCKS, 32'h0000_0001);
    cmd({16'h0700, `OPC_WRITE}, 16'h0004, 0, `ST_EXEC_ERR);
    cmd({16'h0702, `OPC_WRITE}, 16'h0008, 0, `ST_SUCCESS);
    cmd({16'h0701, `OPC_WRITE}, 16'h0000, 0, `ST_SUCCESS);
    u_host_model.wr(`REG_LOCKS, 32'h0000_0003);
    cmd({16'h0701, `OPC_READ}, 16'h0000, 0, `ST_EXEC_ERR);
    cmd({16'h0700, `OPC_READ}, 16'h0000, 0, `ST_SUCCESS);
    u_host_model.wr(`REG_LOCKS, 32'h0000_0007);
    cmd({16'h0701, `OPC_READ}, 16'h0000, 0, `ST_SUCCESS);
    cmd({16'h0701, `OPC_WRITE}, 16'h0000, 0, `ST_EXEC_ERR);
    u_host_model.wr(`REG_LOCKS, 32'h0000_000B);
    cmd({16'h0701, `OPC_WRITE}, 16'h0000, 0, `ST_SUCCESS);
    u_host_model.wr(`REG_SECRET, 32'h0000_0002);
    u_host_model.wr(`REG_ENCREAD, 32'h0000_0002);
    cmd({16'h0702, `OPC_READ}, 16'h0008, 0, `ST_EXEC_ERR);
    cmd({16'h0742, `OPC_READ}, 16'h0008, 0, `ST_SUCCESS);
    cmd({16'h0702, `OPC_READ}, 16'h0000, 0, `ST_SUCCESS);
    u_host_model.wr(`REG_WRPOL_LO, 32'h0000_0240);
    cmd({16'h0702, `OPC_WRITE}, 16'h0000, 0, `ST_SUCCESS);
    cmd({16'h0702, `OPC_WRITE}, 16'h0008, 0, `ST_EXEC_ERR);
    cmd({16'h0742, `OPC_WRITE}, 16'h0008, 0, `ST_SUCCESS);
    cmd({16'h0702, `OPC_WRITE}, 16'h0010, 0, `ST_EXEC_ERR);
    // Register writes during a run must be dropped
    u_host_model.wr(`REG_CMD, {16'h0007, 8'h00, `OPC_HMAC});
    u_host_model.wr(`REG_CTRL, 32'h0000_0001);
    u_host_model.wr(`REG_CMD, 32'h0007_0030);
    u_host_model.wr(`REG_CTRL, 32'h0000_0001);
    u_host_model.rd(`REG_STATUS, st, resp);
    check({31'h0000_0000, st[0]}, 32'h0000_0001);
    u_host_model.poll(0, st);
    check(32'(lastRun), 32'(1 + CYC[3]));
    u_host_model.rd(`REG_CMD, st, resp);
    check(st, {16'h0007, 8'h00, `OPC_HMAC});
    test_done();
  end
endmodule

bind auth_command_decoder_zone_access auth_cmd_asserts #(.KEYDER_CYC(KEYDER_CYC),
  .REVISION_CYC(REVISION_CYC), .DIGEST_CYC(DIGEST_CYC), .HMAC_CYC(HMAC_CYC),
  .CHECKMAC_CYC(CHECKMAC_CYC), .LOCK_CYC(LOCK_CYC), .MAC_CYC(MAC_CYC),
  .NONCE_CYC(NONCE_CYC), .PAUSE_CYC(PAUSE_CYC), .RANDOM_CYC(RANDOM_CYC),
  .READ_CYC(READ_CYC), .CFGUPD_CYC(CFGUPD_CYC), .WRITE_CYC(WRITE_CYC)
) u_auth_cmd_asserts (.core_clk, .rst, .busy, .pinsIgnored, .opStart, .opCode, .statusCode);
